// ---- rtl/pcmc_pkg.sv ----
/*
 * Package for the parity and clock mode control block: register map,
 * field positions, reset values, three-level settings, elasticity buffer
 * marks and the character structs shared by the top and the memory.
 * Assumes a single 200 MHz reference clock (pclk) and an APB master.
 */

package pcmc_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int unsigned APB_AW = 12;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] INT_STAT_OFS = 12'h008;
   localparam logic [11:0] INT_MASK_OFS = 12'h00C;

   // Control register fields
   localparam int unsigned CTRL_W = 14;
   localparam int unsigned CTRL_DEVICE_RESET_N_BIT = 0;
   localparam int unsigned CTRL_PAR_LSB = 1;
   localparam int unsigned CTRL_TXCK_LSB = 3;
   localparam int unsigned CTRL_RXCK_LSB = 5;
   localparam int unsigned CTRL_DEC_LSB = 7;
   localparam int unsigned CTRL_TXOP_LSB = 9;
   localparam int unsigned CTRL_RANGE_LSB = 11;
   localparam int unsigned CTRL_HALF_BIT = 13;
   // Held in reset, codec on, rate range MID, everything else LOW
   localparam logic [13:0] CTRL_RESET = 14'h0A80;

   // Status register fields
   localparam int unsigned STATUS_LEVEL_LSB = 14;
   localparam int unsigned STATUS_STATE_LSB = 18;
   localparam int unsigned STATUS_INVALID_BIT = 21;

   // Interrupt status / mask bits
   localparam int unsigned INT_W = 5;
   localparam int unsigned INT_TX_PARITY = 0;
   localparam int unsigned INT_INSERT = 1;
   localparam int unsigned INT_DROP = 2;
   localparam int unsigned INT_OVERFLOW = 3;
   localparam int unsigned INT_UNDERFLOW = 4;
   localparam logic [4:0] INT_MASK_RESET = 5'h00;

   // ------------------------------------------------------------------
   // Elasticity buffer
   // ------------------------------------------------------------------
   localparam int unsigned EB_AW = 3;
   localparam logic [3:0] EB_DEPTH = 4'h8;
   localparam logic [3:0] EB_NOMINAL = 4'h4;
   localparam logic [3:0] EB_LOW_MARK = 4'h3;
   localparam logic [3:0] EB_HIGH_MARK = 4'h6;
   localparam logic [7:0] K28_5_CHAR = 8'hBC;
   localparam logic [2:0] K_STATUS = 3'h2;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PCMC_LOW = 2'h0,
      PCMC_MID = 2'h1,
      PCMC_HIGH = 2'h2
   } pcmc_tri_t;

   typedef enum logic [2:0] {
      PCMC_EB_FILL = 3'b001,
      PCMC_EB_RUN = 3'b010,
      PCMC_EB_INSERT = 3'b100
   } pcmc_eb_state_t;

   typedef struct packed {
      logic [1:0] ctrl;
      logic [7:0] data;
   } pcmc_tx_char_t;

   typedef struct packed {
      logic framing;
      logic [2:0] status;
      logic [7:0] data;
   } pcmc_rx_char_t;

   typedef struct packed {
      logic half;
      pcmc_tri_t range;
      pcmc_tri_t txop;
      pcmc_tri_t dec;
      pcmc_tri_t rxck;
      pcmc_tri_t txck;
      pcmc_tri_t par;
   } pcmc_cfg_t;

endpackage

// ---- rtl/pcmc_mem.sv ----
/*
 * Small dual-port character store for the elasticity buffer.
 * One write port, one read port; read data come out of a register one
 * cycle after the read enable. Assumes no read and write of one address
 * in the same cycle (the pointer logic keeps them apart).
 */
`timescale 1ns/1ps
`default_nettype none

module pcmc_mem (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [pcmc_pkg::EB_AW-1:0] wr_addr,
   input wire pcmc_pkg::pcmc_rx_char_t wr_data,
   input wire logic rd_en,
   input wire logic [pcmc_pkg::EB_AW-1:0] rd_addr,
   output pcmc_pkg::pcmc_rx_char_t rd_data
);

   pcmc_pkg::pcmc_rx_char_t mem [0:(1 << pcmc_pkg::EB_AW)-1];

   // ------------------------------------------------------------------
   // Storage: array unreset, it is only read after being written
   // ------------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // pcmc_mem

`default_nettype wire

// ---- rtl/pcmc_top.sv ----
/*
 * Parity and clock mode control for a serial transceiver parallel port.
 * Holds the static mode controls in APB registers, checks transmit parity,
 * generates receive parity, and runs a reference-clock elasticity buffer
 * that inserts filler characters or drops framing characters. Assumes pclk is the reference
 * clock, host and recovered streams are synchronous to it, and an APB
 * master that follows the usual two-phase protocol.
 */
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pcmc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcmc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [7:0] transmit_char_in,
   input wire logic [1:0] transmit_ctrl_in,
   input wire logic transmit_parity_in,
   input wire logic transmit_valid_in,
   output logic transmit_ready_out,
   output pcmc_pkg::pcmc_tx_char_t encoder_char_out,
   output logic encoder_valid_out,
   input wire pcmc_pkg::pcmc_rx_char_t recovered_char_in,
   input wire logic recovered_valid_in,
   output logic [7:0] receive_char_out,
   output logic [2:0] receive_status_out,
   output logic receive_valid_out,
   output logic receive_parity_out,
   output logic receive_parity_out_oe,
   output logic delayed_reference_clock_out,
   output logic delayed_reference_clock_out_oe,
   output logic [1:0] serial_rate_range_select,
   output logic transmit_rate_select,
   output logic config_invalid_out,
   output logic device_active_out
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [pcmc_pkg::CTRL_W-1:0] ctrl;
      logic run;
      pcmc_pkg::pcmc_cfg_t cfg;
      logic cfg_invalid;
      logic [pcmc_pkg::INT_W-1:0] int_stat;
      logic [pcmc_pkg::INT_W-1:0] int_mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic tx_ready;
      pcmc_pkg::pcmc_tx_char_t tx_out;
      logic tx_valid;
      pcmc_pkg::pcmc_rx_char_t rx_out;
      logic rx_valid;
      logic rx_par;
      logic rx_par_oe;
      logic dclk;
      logic dclk_oe;
      pcmc_pkg::pcmc_eb_state_t eb_state;
      logic [pcmc_pkg::EB_AW:0] wptr;
      logic [pcmc_pkg::EB_AW:0] rptr;
      logic rd_pend;
   } pcmc_state_t;

   pcmc_state_t s_reg;
   pcmc_state_t s_next;

   logic mem_wr_en;
   logic mem_rd_en;
   pcmc_pkg::pcmc_rx_char_t mem_rd_data;

   logic apb_done;
   logic [pcmc_pkg::INT_W-1:0] ev;
   logic [pcmc_pkg::INT_W-1:0] w1c;
   logic [pcmc_pkg::EB_AW:0] level;
   logic enc_on;
   logic dec_on;
   logic eb_on;
   logic drop_now;
   logic insert_now;
   logic [10:0] tx_cover;
   logic [10:0] rx_cover;
   pcmc_pkg::pcmc_rx_char_t rx_sel;
   logic rx_sel_valid;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Three-level decode; the unused fourth code reads as the open level
   function automatic pcmc_pkg::pcmc_tri_t tri_decode(input logic [1:0] v);
      case (v)
         2'h0: tri_decode = pcmc_pkg::PCMC_LOW;
         2'h2: tri_decode = pcmc_pkg::PCMC_HIGH;
         default: tri_decode = pcmc_pkg::PCMC_MID;
      endcase
   endfunction

   // Bit that makes the covered vector odd
   function automatic logic odd_fill(input logic [11:0] v);
      odd_fill = ~(^v);
   endfunction

   // ------------------------------------------------------------------
   // Elasticity buffer store
   // ------------------------------------------------------------------
   pcmc_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(mem_wr_en),
      .wr_addr(s_reg.wptr[pcmc_pkg::EB_AW-1:0]),
      .wr_data(recovered_char_in),
      .rd_en(mem_rd_en),
      .rd_addr(s_reg.rptr[pcmc_pkg::EB_AW-1:0]),
      .rd_data(mem_rd_data)
   );

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      ev = '0;
      w1c = '0;
      mem_wr_en = 1'b0;
      mem_rd_en = 1'b0;
      insert_now = 1'b0;
      rx_sel = '0;
      rx_sel_valid = 1'b0;

      // APB slave: one wait state, access completes when pready is high
      apb_done = psel && penable && s_reg.pready;
      s_next.pready = psel && penable && !s_reg.pready;
      if (psel && penable && !s_reg.pready) begin
         s_next.pslverr = 1'b0;
         s_next.prdata = '0;
         case (paddr)
            pcmc_pkg::CTRL_OFS: s_next.prdata = {18'h00000, s_reg.ctrl};
            pcmc_pkg::STATUS_OFS: begin
               s_next.prdata = {10'h000, s_reg.cfg_invalid, s_reg.eb_state,
                                s_reg.wptr - s_reg.rptr, s_reg.cfg, s_reg.run};
            end
            pcmc_pkg::INT_STAT_OFS: s_next.prdata = {27'h0000000, s_reg.int_stat};
            pcmc_pkg::INT_MASK_OFS: s_next.prdata = {27'h0000000, s_reg.int_mask};
            default: s_next.pslverr = 1'b1; // Unmapped address
         endcase
      end
      if (apb_done && pwrite) begin
         case (paddr)
            pcmc_pkg::CTRL_OFS: s_next.ctrl = pwdata[pcmc_pkg::CTRL_W-1:0];
            pcmc_pkg::INT_STAT_OFS: w1c = pwdata[pcmc_pkg::INT_W-1:0];
            pcmc_pkg::INT_MASK_OFS: s_next.int_mask = pwdata[pcmc_pkg::INT_W-1:0];
            default: ;
         endcase
      end

      // Device reset bit sampled on the clock; while low the static
      // controls follow the register, once high they are frozen
      s_next.run = s_reg.ctrl[pcmc_pkg::CTRL_DEVICE_RESET_N_BIT];
      if (!s_reg.run) begin
         s_next.cfg.par = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_PAR_LSB +: 2]);
         s_next.cfg.txck = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_TXCK_LSB +: 2]);
         s_next.cfg.rxck = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_RXCK_LSB +: 2]);
         s_next.cfg.dec = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_DEC_LSB +: 2]);
         s_next.cfg.txop = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_TXOP_LSB +: 2]);
         s_next.cfg.range = tri_decode(s_reg.ctrl[pcmc_pkg::CTRL_RANGE_LSB +: 2]);
         s_next.cfg.half = s_reg.ctrl[pcmc_pkg::CTRL_HALF_BIT];
      end
      // Only flagged: the PLL side owns this combination
      s_next.cfg_invalid = (s_reg.cfg.range == pcmc_pkg::PCMC_LOW) && s_reg.cfg.half;

      enc_on = s_reg.cfg.txop != pcmc_pkg::PCMC_LOW;
      dec_on = s_reg.cfg.dec != pcmc_pkg::PCMC_LOW;

      // Transmit parity coverage; a mixed codec setting uses the encoder's side
      case (s_reg.cfg.par)
         pcmc_pkg::PCMC_MID: begin
            tx_cover = enc_on ? {transmit_parity_in, 2'b00, transmit_char_in}
                              : {transmit_parity_in, transmit_ctrl_in, transmit_char_in};
         end
         pcmc_pkg::PCMC_HIGH: tx_cover = {transmit_parity_in, transmit_ctrl_in, transmit_char_in};
         default: tx_cover = '0;
      endcase

      // Transmit capture on the reference clock only
      s_next.tx_ready = s_next.run && (s_next.cfg.txck == pcmc_pkg::PCMC_LOW);
      s_next.tx_valid = s_reg.tx_ready && transmit_valid_in;
      if (s_reg.tx_ready && transmit_valid_in) begin
         s_next.tx_out = {transmit_ctrl_in, transmit_char_in};
         // Odd parity holds when the fill bit over the whole vector is zero
         if (s_reg.cfg.par != pcmc_pkg::PCMC_LOW && odd_fill({1'b0, tx_cover})) begin
            ev[pcmc_pkg::INT_TX_PARITY] = 1'b1;
         end
      end

      // Elasticity buffer
      level = s_reg.wptr - s_reg.rptr;
      eb_on = s_reg.run && (s_reg.cfg.rxck == pcmc_pkg::PCMC_LOW);
      // Only a framing character may be dropped, and only at or above the high mark
      drop_now = eb_on && recovered_valid_in && recovered_char_in.framing &&
                 (level >= pcmc_pkg::EB_HIGH_MARK);
      if (eb_on && recovered_valid_in && !drop_now) begin
         if (level == pcmc_pkg::EB_DEPTH) begin
            ev[pcmc_pkg::INT_OVERFLOW] = 1'b1;
         end else begin
            mem_wr_en = 1'b1;
         end
      end
      ev[pcmc_pkg::INT_DROP] = drop_now;

      if (eb_on) begin
         case (s_reg.eb_state)
            pcmc_pkg::PCMC_EB_FILL: begin
               // Start reading once the nominal offset has built up
               if (level >= pcmc_pkg::EB_NOMINAL) begin
                  s_next.eb_state = pcmc_pkg::PCMC_EB_RUN;
               end
            end
            pcmc_pkg::PCMC_EB_RUN: begin
               insert_now = s_reg.rd_pend && mem_rd_data.framing &&
                            (level < pcmc_pkg::EB_LOW_MARK);
               if (insert_now) begin
                  s_next.eb_state = pcmc_pkg::PCMC_EB_INSERT;
               end else if (level != '0) begin
                  mem_rd_en = 1'b1;
               end else begin
                  ev[pcmc_pkg::INT_UNDERFLOW] = 1'b1;
               end
            end
            pcmc_pkg::PCMC_EB_INSERT: begin
               s_next.eb_state = pcmc_pkg::PCMC_EB_RUN;
               mem_rd_en = level != '0;
            end
            default: s_next.eb_state = pcmc_pkg::PCMC_EB_FILL;
         endcase
         if (s_reg.rd_pend) begin
            rx_sel = mem_rd_data;
            rx_sel_valid = 1'b1;
         end else if (s_reg.eb_state == pcmc_pkg::PCMC_EB_INSERT) begin
            // Filler character right behind the framing character
            rx_sel = {1'b0, pcmc_pkg::K_STATUS, pcmc_pkg::K28_5_CHAR};
            rx_sel_valid = 1'b1;
            ev[pcmc_pkg::INT_INSERT] = 1'b1;
         end
         s_next.wptr = s_reg.wptr + {3'b000, mem_wr_en};
         s_next.rptr = s_reg.rptr + {3'b000, mem_rd_en};
         s_next.rd_pend = mem_rd_en;
      end else begin
         // Buffer off: pointers parked, recovered stream passes straight on
         s_next.eb_state = pcmc_pkg::PCMC_EB_FILL;
         s_next.wptr = '0;
         s_next.rptr = '0;
         s_next.rd_pend = 1'b0;
         rx_sel = recovered_char_in;
         rx_sel_valid = s_reg.run && recovered_valid_in;
      end

      // Receive output register and parity generation
      s_next.rx_valid = rx_sel_valid;
      if (rx_sel_valid) begin
         s_next.rx_out = rx_sel;
      end
      case (s_reg.cfg.par)
         pcmc_pkg::PCMC_MID: begin
            rx_cover = dec_on ? {3'b000, s_next.rx_out.data}
                              : {1'b0, s_next.rx_out.status[1:0], s_next.rx_out.data};
         end
         pcmc_pkg::PCMC_HIGH: rx_cover = {s_next.rx_out.status, s_next.rx_out.data};
         default: rx_cover = '0;
      endcase
      s_next.rx_par = odd_fill({1'b0, rx_cover});
      s_next.rx_par_oe = s_reg.run && (s_reg.cfg.par != pcmc_pkg::PCMC_LOW);

      // Half-rate copy of the reference clock, driven only in buffered mode
      s_next.dclk = eb_on ? !s_reg.dclk : 1'b0;
      s_next.dclk_oe = eb_on;

      // Held device: clear the datapath state
      if (!s_reg.run) begin
         s_next.tx_out = '0;
         s_next.tx_valid = 1'b0;
         s_next.rx_out = '0;
         s_next.rx_valid = 1'b0;
      end

      // Sticky interrupts: a new event wins over a same-cycle clear
      s_next.int_stat = (s_reg.int_stat & ~w1c) | ev;
      s_next.irq = |(s_next.int_stat & s_next.int_mask);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.ctrl <= pcmc_pkg::CTRL_RESET;
         s_reg.cfg.dec <= pcmc_pkg::PCMC_MID;
         s_reg.cfg.txop <= pcmc_pkg::PCMC_MID;
         s_reg.cfg.range <= pcmc_pkg::PCMC_MID;
         s_reg.int_mask <= pcmc_pkg::INT_MASK_RESET;
         s_reg.eb_state <= pcmc_pkg::PCMC_EB_FILL;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all straight from the state register
   // ------------------------------------------------------------------
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign irq = s_reg.irq;
   assign transmit_ready_out = s_reg.tx_ready;
   assign encoder_char_out = s_reg.tx_out;
   assign encoder_valid_out = s_reg.tx_valid;
   assign receive_char_out = s_reg.rx_out.data;
   assign receive_status_out = s_reg.rx_out.status;
   assign receive_valid_out = s_reg.rx_valid;
   assign receive_parity_out = s_reg.rx_par;
   assign receive_parity_out_oe = s_reg.rx_par_oe;
   assign delayed_reference_clock_out = s_reg.dclk;
   assign delayed_reference_clock_out_oe = s_reg.dclk_oe;
   assign serial_rate_range_select = s_reg.cfg.range;
   assign transmit_rate_select = s_reg.cfg.half;
   assign config_invalid_out = s_reg.cfg_invalid;
   assign device_active_out = s_reg.run;

endmodule // pcmc_top

`default_nettype wire

// ---- verification/pcmc_props.sv ----
/*
 * Checker for pcmc_top: character capture, parity fill, delayed clock
 * output and frozen configuration, watched at the top module's ports.
 * Assumes one clock, pclk, and the asynchronous active-low presetn.
 */
`timescale 1ns/1ps
`default_nettype none

module pcmc_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] transmit_char_in,
   input wire logic [1:0] transmit_ctrl_in,
   input wire logic transmit_valid_in,
   input wire logic transmit_ready_out,
   input wire pcmc_pkg::pcmc_tx_char_t encoder_char_out,
   input wire logic encoder_valid_out,
   input wire pcmc_pkg::pcmc_rx_char_t recovered_char_in,
   input wire logic recovered_valid_in,
   input wire logic [7:0] receive_char_out,
   input wire logic [2:0] receive_status_out,
   input wire logic receive_valid_out,
   input wire logic receive_parity_out,
   input wire logic receive_parity_out_oe,
   input wire logic delayed_reference_clock_out,
   input wire logic delayed_reference_clock_out_oe,
   input wire logic [1:0] serial_rate_range_select,
   input wire logic transmit_rate_select,
   input wire logic device_active_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Captured character shows the next cycle, exactly as launched
   property p_enc_take;
      transmit_ready_out && transmit_valid_in |=> encoder_valid_out
         && encoder_char_out == $past({transmit_ctrl_in, transmit_char_in});
   endproperty
   a_enc_take: assert property (p_enc_take) else $error("capture lost");
   property p_enc_only;
      encoder_valid_out |-> $past(transmit_ready_out && transmit_valid_in);
   endproperty
   a_enc_only: assert property (p_enc_only) else $error("spurious capture");
   // Any of the three coverages must come out odd
   property p_par_odd;
      receive_valid_out && receive_parity_out_oe |-> ^{receive_char_out, receive_parity_out}
         || ^{receive_char_out, receive_status_out[1:0], receive_parity_out}
         || ^{receive_char_out, receive_status_out, receive_parity_out};
   endproperty
   a_par_odd: assert property (p_par_odd) else $error("parity not odd");
   property p_clk_oe;
      !delayed_reference_clock_out_oe |-> !delayed_reference_clock_out;
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock out undriven");
   property p_clk_run;
      delayed_reference_clock_out_oe && $past(delayed_reference_clock_out_oe)
         |-> delayed_reference_clock_out != $past(delayed_reference_clock_out);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock out stuck");
   // One cycle of slack: both oe outputs follow the run flag by a register
   property p_held;
      !device_active_out && !$past(device_active_out) |-> !transmit_ready_out
         && !receive_parity_out_oe && !delayed_reference_clock_out_oe;
   endproperty
   a_held: assert property (p_held) else $error("active while held");
   property p_frozen;
      device_active_out && $past(device_active_out)
         |-> $stable(serial_rate_range_select) && $stable(transmit_rate_select);
   endproperty
   a_frozen: assert property (p_frozen) else $error("config moved");
   property p_pass;
      recovered_valid_in && device_active_out && $past(device_active_out)
         && !delayed_reference_clock_out_oe
         |=> receive_valid_out && receive_char_out == $past(recovered_char_in.data);
   endproperty
   a_pass: assert property (p_pass) else $error("pass-through lost");
endmodule // pcmc_props

bind pcmc_top pcmc_props u_props (.*);

`default_nettype wire

// ---- verification/pcmc_host.sv ----
/*
 * Host model on the parallel transmit side: launches one character per
 * send request with odd parity over the coverage of the current mode, even parity when bad is set.
 * Assumes the bench raises send only while the device takes characters.
 */
`timescale 1ns/1ps
`default_nettype none

module pcmc_host (
   input wire logic pclk,
   input wire logic send,
   input wire logic bad,
   input wire logic [1:0] par,
   input wire logic codec,
   input wire logic [9:0] word,
   output logic [7:0] tx_data,
   output logic [1:0] tx_ctrl,
   output logic tx_par,
   output logic tx_valid
);
   logic [11:0] drv = 12'h000;
   logic [1:0] cov_ctrl;
   assign {tx_valid, tx_par, tx_ctrl, tx_data} = drv;
   // Control bits join when HIGH, or MID with the encoder off
   assign cov_ctrl = {2{par == 2'h2 || (par == 2'h1 && !codec)}};
   // Launched off the reference clock; idle lines invert so stale data never looks valid
   always @(posedge pclk) begin
      if (send) begin
         drv <= {1'b1, ~^{word[7:0], cov_ctrl & word[9:8]} ^ bad, word};
      end else begin
         drv <= {2'b00, ~drv[9:0]};
      end
   end
endmodule // pcmc_host

`default_nettype wire

// ---- verification/pcmc_bench.sv ----
/*
 * Self-checking bench for pcmc_top: APB set-up, transmit parity events,
 * receive parity and the buffered path, against queue-based expectations.
 * Assumes pclk is the reference clock and a pcmc_host on the transmit side.
 */
`timescale 1ns/1ps
`default_nettype none

module pcmc_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rv, seed = 32'h0000C927;
   logic pready, pslverr, irq, er, send = 1'b0, bad = 1'b0, cur_codec = 1'b0;
   logic [7:0] transmit_char_in, receive_char_out;
   logic [1:0] transmit_ctrl_in, serial_rate_range_select, cur_par = 2'h0;
   logic [2:0] receive_status_out, cov_st;
   logic transmit_parity_in, transmit_valid_in, transmit_ready_out, encoder_valid_out;
   logic receive_valid_out, receive_parity_out, receive_parity_out_oe, device_active_out;
   logic delayed_reference_clock_out, delayed_reference_clock_out_oe;
   logic transmit_rate_select, config_invalid_out, recovered_valid_in = 1'b0;
   logic [9:0] word = 10'h000;
   pcmc_pkg::pcmc_tx_char_t encoder_char_out;
   pcmc_pkg::pcmc_rx_char_t recovered_char_in = '0, exp_rx;
   logic [9:0] tx_q[$];
   pcmc_pkg::pcmc_rx_char_t rx_q[$];
   int n_errors = 0, compares = 0;

   pcmc_top u_dut (.*);
   pcmc_host u_host (.pclk(pclk), .send(send), .bad(bad), .par(cur_par), .codec(cur_codec),
      .word(word), .tx_data(transmit_char_in), .tx_ctrl(transmit_ctrl_in),
      .tx_par(transmit_parity_in), .tx_valid(transmit_valid_in));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   always #2.5 pclk = ~pclk;
   assign cov_st = cur_par == 2'h2 ? 3'h7 : (cur_par == 2'h1 && !cur_codec) ? 3'h3 : 3'h0;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic results();
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Mode changes only while held; range MID keeps full rate legal
   task automatic cfg(input logic [1:0] par, input logic cod, input logic [1:0] rxck);
      logic [31:0] c;
      c = {18'h0, 1'b0, 2'h1, 1'b0, cod, 1'b0, cod, rxck, 2'h0, par, 1'b0};
      apb(1'b1, pcmc_pkg::CTRL_OFS, c);
      cur_par = par;
      cur_codec = cod;
      apb(1'b1, pcmc_pkg::CTRL_OFS, c | 32'h1);
      repeat (3) @(posedge pclk);
   endtask

   task automatic tx(input logic b);
      logic [31:0] r;
      r = rnd();
      @(posedge pclk);
      send <= 1'b1;
      bad <= b;
      word <= r[9:0];
      tx_q.push_back(r[9:0]);
      @(posedge pclk);
      send <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, pcmc_pkg::INT_STAT_OFS, 32'h0);
      chk("parity event", rv & 32'h1, {31'h0, b && cur_par != 2'h0});
      chk("irq raised", irq, b && cur_par != 2'h0);
      apb(1'b1, pcmc_pkg::INT_STAT_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", irq, 1'b0);
   endtask

   // Last character framing when fr: buffered mode then appends a filler
   task automatic rx(input int n, input logic fr);
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         r = rnd();
         @(posedge pclk);
         recovered_valid_in <= 1'b1;
         recovered_char_in <= {fr && i == n - 1, r[10:0]};
         rx_q.push_back({fr && i == n - 1, r[10:0]});
      end
      if (fr) rx_q.push_back({1'b0, pcmc_pkg::K_STATUS, pcmc_pkg::K28_5_CHAR});
      @(posedge pclk);
      recovered_valid_in <= 1'b0;
      recovered_char_in <= ~recovered_char_in;
      repeat (12) @(posedge pclk);
   endtask

   // Every output character against the expected stream
   always @(posedge pclk) begin
      if (encoder_valid_out === 1'b1) chk("tx char", 32'(encoder_char_out), 32'(tx_q.pop_front()));
      if (receive_valid_out === 1'b1) begin
         exp_rx = rx_q.pop_front();
         chk("rx char", {receive_status_out, receive_char_out}, 32'(exp_rx[10:0]));
         chk("rx parity oe", receive_parity_out_oe, cur_par != 2'h0);
         if (cur_par != 2'h0) chk("rx parity", receive_parity_out,
            ~^{exp_rx.data, cov_st & exp_rx.status});
      end
   end

   initial begin
      repeat (1000) @(posedge pclk);
      n_errors++;
      results();
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, pcmc_pkg::CTRL_OFS, 32'h0);
      chk("ctrl reset", rv, 32'h00000A80);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", er, 1'b1);
      apb(1'b1, pcmc_pkg::INT_MASK_OFS, 32'h1);
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 2; k++) begin
            cfg(p[1:0], k[0], 2'h1);
            tx(1'b0);
            tx(1'b1);
            rx(3, 1'b0);
         end
      end
      cfg(2'h2, 1'b1, 2'h0);
      chk("ref clock oe", delayed_reference_clock_out_oe, 1'b1);
      rx(10, 1'b1);
      apb(1'b0, pcmc_pkg::INT_STAT_OFS, 32'h0);
      chk("buffer events", rv & 32'h1E, 32'h12);
      chk("rx backlog", rx_q.size(), 32'h0);
      results();
   end
endmodule // pcmc_bench

`default_nettype wire
